// >>> bench/drs_partner.sv
/*
 * drs_partner: power stage and search algorithm stand-in for drs_top.
 * Assumes the bench asks for a trip by a one-cycle trip_req on core_clk.
 */
`timescale 1ns/1ps
module drs_partner
    import drs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // bench side
    input wire logic trip_req,
    input wire drs_trip_t cause_req,
    input wire logic search_hang,
    // supervisor side
    input wire logic auto_reset_cmd,
    input wire logic manual_reset,
    input wire logic search_active,
    output logic trip_active,
    output drs_trip_t trip_cause,
    output logic search_done
);
    logic [2:0] srch_cnt;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            trip_active <= 1'b0;
            trip_cause <= '0;
            srch_cnt <= 3'h0;
        end else begin
            if (auto_reset_cmd || manual_reset) begin
                trip_active <= 1'b0;
            end else if (trip_req) begin
                trip_active <= 1'b1;
                trip_cause <= cause_req;
            end
            srch_cnt <= search_active ? srch_cnt + 3'h1 : 3'h0;
        end
    end
    assign search_done = (srch_cnt == 3'h4) && !search_hang;
endmodule // drs_partner

// >>> bench/drs_top_tb.sv
/*
 * drs_top_tb: scenario tasks for retry, init table, search, ramp and fan hold.
 * Assumes drs_partner closes the trip and search loops; TICK_CYC is shortened.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module drs_top_tb
    import drs_pkg::*;
;
    logic core_clk, reset, trip_req, manual_reset, fan_control_select, drive_running;
    logic temp_low_pin, start_cmd, restart_pf, trip_active, search_done, auto_reset_cmd;
    logic retry_active_output, alarm_out, fan_on, search_active, accel_go, init_done;
    drs_trip_t cause_req, trip_cause;
    drs_motor_par_t motor_par;
    logic [3:0] retry_count_setting;
    logic [7:0] retry_interval_setting, output_one_assign, output_two_assign;
    logic [7:0] relay_output_assign, search_delay_setting;
    logic [2:0] terminal_out, motor_type_select;
    logic [1:0] ramp_pattern_select, idle_search_select, parameter_init_select;
    logic [15:0] target_freq, ramp_step, out_freq, rated_capacity_setting;
    logic [4:0][7:0] input_terminal_assign;
    logic [4:0] din_pin;
    logic search_hang;
    int err_total, num_checks, cyc;
    drs_top #(.TICK_CYC(4)) dut (.*, .max_freq(16'h03E8), .base_freq(16'h01F4));
    drs_partner partner (.*);
    // ************************************************
    // clock, timeout, verdict
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task conclude();
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            conclude();
        end
    end
    // ************************************************
    // scenarios
    // ************************************************
    task t_trip(input drs_trip_t c, input logic ok);
        int n;
        @(posedge core_clk) trip_req <= 1'b1;
        cause_req <= c;
        @(posedge core_clk) trip_req <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK("retry_active", ok, retry_active_output)
        `CHK("alarm", !ok, alarm_out)
        if (ok) begin
            `CHK("terminal", 3'h1, terminal_out)
            for (n = 0; n < 30 && auto_reset_cmd !== 1'b1; n++) @(negedge core_clk);
            `CHK("interval", 1'b1, n >= 2 && n <= 10)
        end else begin
            @(posedge core_clk) manual_reset <= 1'b1;
            @(posedge core_clk) manual_reset <= 1'b0;
            repeat (2) @(negedge core_clk);
            `CHK("alarm_clear", 1'b0, alarm_out)
        end
        repeat (2) @(posedge core_clk);
    endtask
    task t_retry();
        @(posedge core_clk) retry_count_setting <= 4'hF;
        for (int i = 0; i < 6; i++) t_trip(drs_trip_t'(7'h01 << i), 1'b1);
        t_trip(7'h40, 1'b0);
        @(posedge core_clk) retry_count_setting <= 4'h2;
        t_trip(7'h01, 1'b1);
        t_trip(7'h02, 1'b1);
        t_trip(7'h01, 1'b0);
        @(posedge core_clk) retry_count_setting <= 4'h0;
        t_trip(7'h01, 1'b0);
    endtask
    task t_init(input logic [15:0] cap, input logic [2:0] ty, input drs_motor_par_t ex);
        @(posedge core_clk) rated_capacity_setting <= cap;
        motor_type_select <= ty;
        parameter_init_select <= 2'h2;
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK("init_done", 1'b1, init_done)
        `CHK("motor_par", ex, motor_par)
        @(posedge core_clk) parameter_init_select <= 2'h0;
    endtask
    task t_start(input logic [1:0] md, input logic pf, input logic ex);
        int n;
        logic seen;
        seen = 1'b0;
        @(posedge core_clk) idle_search_select <= md;
        restart_pf <= pf;
        start_cmd <= !pf;
        @(posedge core_clk) restart_pf <= 1'b0;
        start_cmd <= 1'b0;
        for (n = 0; n < 60 && accel_go !== 1'b1; n++) begin
            @(negedge core_clk);
            seen |= (search_active === 1'b1);
        end
        `CHK("accel_go", 1'b1, accel_go)
        `CHK("search_seen", ex, seen)
    endtask
    task t_ramp();
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk) ramp_pattern_select <= p[1:0];
            target_freq <= p[0] ? 16'h0000 : 16'h0320;
            repeat (400) @(posedge core_clk);
            @(negedge core_clk);
            `CHK("out_freq", (p[0] ? 16'h0000 : 16'h0320), out_freq)
        end
    endtask
    task t_fan();
        @(negedge core_clk);
        `CHK("fan_always", 1'b1, fan_on)
        @(posedge core_clk) fan_control_select <= 1'b1;
        repeat (15000) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("fan_hold", 1'b1, fan_on)
        repeat (12000) @(negedge core_clk);
        `CHK("fan_off", 1'b0, fan_on)
        @(posedge core_clk) drive_running <= 1'b1;
        repeat (5) @(negedge core_clk);
        `CHK("fan_run", 1'b1, fan_on)
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {reset, trip_req, manual_reset, fan_control_select, drive_running} = 5'h10;
        {start_cmd, restart_pf, cause_req, din_pin, input_terminal_assign, search_hang} = '0;
        temp_low_pin = 1'b1;
        retry_count_setting = 4'h3;
        retry_interval_setting = 8'h02;
        output_one_assign = 8'h1A;
        output_two_assign = 8'h05;
        relay_output_assign = 8'h00;
        search_delay_setting = 8'h00;
        {ramp_pattern_select, idle_search_select, parameter_init_select} = '0;
        {target_freq, rated_capacity_setting, motor_type_select} = '0;
        ramp_step = 16'h0005;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_retry();
        t_init(16'h0005, 3'h0, {16'h0016, 16'h0014, 16'h0563, 16'h0497, 16'h00B1});
        t_init(16'h0898, 3'h4, {16'h0F3C, 16'h04EC, 16'h010E, 16'h0640, 16'h005A});
        t_init(16'h0005, 3'h1, {16'h0F3C, 16'h04EC, 16'h010E, 16'h0640, 16'h005A});
        t_start(2'h2, 1'b0, 1'b1);
        t_start(2'h1, 1'b0, 1'b0);
        t_start(2'h1, 1'b1, 1'b1);
        t_start(2'h0, 1'b1, 1'b0);
        @(posedge core_clk) input_terminal_assign[2] <= 8'h1A;
        din_pin[2] <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_start(2'h0, 1'b0, 1'b1);
        @(posedge core_clk) search_hang <= 1'b1;
        t_start(2'h0, 1'b0, 1'b1);
        t_ramp();
        t_fan();
        conclude();
    end
endmodule // drs_top_tb

// >>> hw/drs_motor_table.sv
/*
 * drs_motor_table: maps a rated capacity onto its nominal band and row.
 * Assumes capacity in hundredths of a kW; purely combinational.
 */
`timescale 1ns/1ps
module drs_motor_table
    import drs_pkg::*;
(
    // capacity in
    input wire logic [15:0] capacity,
    // table row out
    output drs_motor_par_t par,
    output logic [3:0] band
);

    // ************************************************
    // band search
    // ************************************************
    logic [NUM_BANDS-1:0] at_or_above;
    logic [4:0] ones;

    for (genvar gi = 0; gi < NUM_BANDS; gi++) begin : g_band
        assign at_or_above[gi] = capacity >= BAND_LO[gi];
    end
    assign ones = 5'($countones(at_or_above));
    assign band = (ones == 5'h00) ? 4'h0 : 4'(ones - 5'h01);

    assign par = {RATED_TBL[band], NOLOAD_TBL[band], PCT_R_TBL[band], PCT_X_TBL[band],
        SLIP_TBL[band]};

endmodule // drs_motor_table

// >>> hw/drs_pkg.sv
/*
 * drs_pkg: constants, tables, enums and carriers for the run supervisor.
 * Assumes a single 125 MHz control clock; times are counted in tenths of a second.
 */
package drs_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int TENTH_NS = 100_000_000;
    localparam int TENTH_CYC = TENTH_NS / CLK_PERIOD_NS;
    localparam int FAN_HOLD_MIN = 10;
    localparam int FAN_HOLD_TENTHS = FAN_HOLD_MIN * 600;
    localparam int SEARCH_MAX_MS = 1200;
    localparam int SEARCH_MAX_TENTHS = SEARCH_MAX_MS / 100;

    // ************************************************
    // setting codes
    // ************************************************
    localparam logic [7:0] RETRY_OUT_CODE = 8'h1A;
    localparam logic [7:0] SEARCH_IN_CODE = 8'h1A;
    localparam logic [3:0] RETRY_OFF = 4'h0;
    localparam logic FAN_CTRL = 1'h1;
    localparam logic [1:0] INIT_MOTOR = 2'h2;
    localparam logic [2:0] MOTOR_STD = 3'h0;
    localparam logic [2:0] MOTOR_OTHER = 3'h4;
    localparam int S_WEAK_DIV = 20;
    localparam int S_STRONG_DIV = 10;

    typedef enum logic [1:0] {RAMP_LINEAR, RAMP_S_WEAK, RAMP_S_STRONG, RAMP_CURVE} drs_ramp_t;
    typedef enum logic [1:0] {SEARCH_OFF, SEARCH_PF, SEARCH_ALL} drs_search_t;
    typedef enum logic [1:0] {RT_IDLE, RT_WAIT, RT_ALARM} drs_retry_st_t;
    typedef enum logic [1:0] {SR_IDLE, SR_DELAY, SR_RUN} drs_search_st_t;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic other;
        logic inv_ol;
        logic mot_ol;
        logic mot_oh;
        logic hs_oh;
        logic ov;
        logic oc;
    } drs_trip_t;

    typedef struct packed {
        logic [15:0] rated_cur;
        logic [15:0] noload_cur;
        logic [15:0] pct_r;
        logic [15:0] pct_x;
        logic [15:0] slip;
    } drs_motor_par_t;

    // ************************************************
    // capacity table, all in hundredths
    // ************************************************
    localparam int NUM_BANDS = 14;
    localparam logic [15:0] BAND_LO [NUM_BANDS] = '{16'h0001, 16'h000A, 16'h0014,
        16'h0028, 16'h004B, 16'h0096, 16'h00DC, 16'h0172, 16'h0226, 16'h02EE,
        16'h044C, 16'h05DC, 16'h073A, 16'h0898};
    localparam logic [15:0] RATED_TBL [NUM_BANDS] = '{16'h0016, 16'h0023, 16'h0041,
        16'h0073, 16'h00B4, 16'h0136, 16'h01CC, 16'h02EE, 16'h047E, 16'h05AA,
        16'h0834, 16'h0ABE, 16'h0D48, 16'h0F3C};
    localparam logic [15:0] NOLOAD_TBL [NUM_BANDS] = '{16'h0014, 16'h001B, 16'h0035,
        16'h0053, 16'h0073, 16'h0097, 16'h00F3, 16'h0180, 16'h0226, 16'h0271,
        16'h0375, 16'h03E8, 16'h042E, 16'h04EC};
    localparam logic [15:0] PCT_R_TBL [NUM_BANDS] = '{16'h0563, 16'h0510, 16'h050F,
        16'h03FC, 16'h0363, 16'h028F, 16'h0288, 16'h0243, 16'h0210, 16'h01C2,
        16'h017A, 16'h0145, 16'h0124, 16'h010E};
    localparam logic [15:0] PCT_X_TBL [NUM_BANDS] = '{16'h0497, 16'h04F3, 16'h050C,
        16'h0556, 16'h0434, 16'h0461, 16'h0449, 16'h0465, 16'h0597, 16'h05BC,
        16'h05E5, 16'h0665, 16'h067A, 16'h0640};
    localparam logic [15:0] SLIP_TBL [NUM_BANDS] = '{16'h00B1, 16'h00B1, 16'h00E9,
        16'h00F0, 16'h00E9, 16'h00C8, 16'h00B4, 16'h00C1, 16'h008C, 16'h009D,
        16'h006B, 16'h0071, 16'h0057, 16'h005A};

endpackage

// >>> hw/drs_ramp_shape.sv
/*
 * drs_ramp_shape: steps the output frequency toward the target per pattern.
 * Assumes step is the linear per-cycle change set by the reference ramp time.
 */
`timescale 1ns/1ps
module drs_ramp_shape
    import drs_pkg::*;
#(
    parameter int FW = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // ramp setup
    input wire logic [1:0] pattern,
    input wire logic [FW-1:0] target,
    input wire logic [FW-1:0] max_freq,
    input wire logic [FW-1:0] base_freq,
    input wire logic [FW-1:0] step,
    // ramp result
    output logic [FW-1:0] out_freq
);

    logic [FW-1:0] start_f;
    drs_ramp_t pat;
    logic up;
    logic [FW-1:0] dist_end, dist_start, zone, half, rate, adv;
    logic in_zone, above_base;

    assign pat = drs_ramp_t'(pattern);
    assign up = target > out_freq;
    assign dist_end = up ? target - out_freq : out_freq - target;
    assign dist_start = (out_freq > start_f) ? out_freq - start_f : start_f - out_freq;
    assign zone = (pat == RAMP_S_WEAK) ? max_freq / FW'(S_WEAK_DIV)
        : (pat == RAMP_S_STRONG) ? max_freq / FW'(S_STRONG_DIV) : '0;
    assign in_zone = (dist_end < zone) || (dist_start < zone);
    assign above_base = (pat == RAMP_CURVE) && (out_freq > base_freq);
    assign half = (step > FW'(1)) ? step >> 1 : step;
    assign rate = (in_zone || above_base) ? half : step;
    assign adv = (dist_end < rate) ? dist_end : rate;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_freq <= '0;
            start_f <= '0;
        end else begin
            out_freq <= up ? out_freq + adv : out_freq - adv;
            if (dist_end == '0) begin
                start_f <= out_freq;
            end
        end
    end

    property p_linear_rate;
        @(posedge core_clk) disable iff (reset)
        (pat == RAMP_LINEAR && up && dist_end >= step && $stable(target))
            |=> out_freq == $past(out_freq) + $past(step);
    endproperty
    a_linear_rate: assert property (p_linear_rate) else $error("linear ramp rate wrong");

    property p_s_middle;
        @(posedge core_clk) disable iff (reset)
        (pat == RAMP_S_STRONG && up && !in_zone && dist_end >= step)
            |=> out_freq == $past(out_freq) + $past(step);
    endproperty
    a_s_middle: assert property (p_s_middle) else $error("s-curve middle rate wrong");

endmodule // drs_ramp_shape

// >>> hw/drs_top.sv
/*
 * drs_top: retry, fan hold, ramp shape, start search and motor table loading.
 * Assumes trip, run and start signals come from logic on core_clk; pins are synced here.
 */
`timescale 1ns/1ps
// How it works
// - Eligible trips wait, then clear themselves without alarm while retries remain.
// - Trips beyond the retry count raise the alarm and stop retrying.
// - Retry count zero disables retry; otherwise it limits attempts.
// - Only overcurrent, overvoltage, overheat and overload trips may retry.
// - After the retry interval in the trip, pulse the internal reset.
// - Outputs assigned code 26 show retry in progress.
// - Controlled fan stops when stopped and temperature is low.
// - Fan runs at least ten minutes once started.
// - Fan select 0 always on, 1 temperature controlled.
// - Linear pattern changes frequency at constant rate.
// - S-curves round ramp ends over 5 or 10 percent zones.
// - Reference rate governs only the linear middle of S-curves.
// - Curvilinear ramp slows above base frequency.
// - Search applies to power-failure restart and normal start.
// - Inputs assigned code 26 give search-at-start; none means off.
// - Motor parameters come from the capacity band table.
// - Init select 2 reloads motor parameters by capacity and type.
// - Off-nominal capacity is forced to its nominal band.
// - Normal start searches at mode 2 or input on; restart at 1, 2.
// - Search lasts at most 1.2 seconds before acceleration.
module drs_top
    import drs_pkg::*;
#(
    parameter int TICK_CYC = TENTH_CYC,
    parameter int NUM_DIN = 5,
    parameter int FW = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // trips and manual reset
    input wire logic trip_active,
    input wire drs_trip_t trip_cause,
    input wire logic manual_reset,
    // retry
    input wire logic [3:0] retry_count_setting,
    input wire logic [7:0] retry_interval_setting,
    output logic auto_reset_cmd,
    output logic retry_active_output,
    output logic alarm_out,
    // output terminals
    input wire logic [7:0] output_one_assign,
    input wire logic [7:0] output_two_assign,
    input wire logic [7:0] relay_output_assign,
    output logic [2:0] terminal_out,
    // fan
    input wire logic fan_control_select,
    input wire logic drive_running,
    input wire logic temp_low_pin,
    output logic fan_on,
    // ramp
    input wire logic [1:0] ramp_pattern_select,
    input wire logic [FW-1:0] target_freq,
    input wire logic [FW-1:0] max_freq,
    input wire logic [FW-1:0] base_freq,
    input wire logic [FW-1:0] ramp_step,
    output logic [FW-1:0] out_freq,
    // search
    input wire logic [1:0] idle_search_select,
    input wire logic [7:0] search_delay_setting,
    input wire logic [NUM_DIN-1:0][7:0] input_terminal_assign,
    input wire logic [NUM_DIN-1:0] din_pin,
    input wire logic start_cmd,
    input wire logic restart_pf,
    input wire logic search_done,
    output logic search_active,
    output logic accel_go,
    // motor parameter init
    input wire logic [1:0] parameter_init_select,
    input wire logic [15:0] rated_capacity_setting,
    input wire logic [2:0] motor_type_select,
    output drs_motor_par_t motor_par,
    output logic init_done
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // ************************************************
    // tenth-second tick
    // ************************************************
    logic [31:0] tick_cnt;
    logic tick;
    assign tick = tick_cnt == 32'(TICK_CYC - 1);

    always_ff @(posedge core_clk) begin
        if (reset || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // ************************************************
    // retry supervisor
    // ************************************************
    drs_retry_st_t rt, next_rt;
    logic trip_d;
    logic [3:0] attempts, count_d;
    logic [7:0] rt_timer;
    logic trip_start, eligible, can_retry, fire, count_chg;

    assign trip_start = trip_active && !trip_d;
    assign eligible = |{trip_cause.oc, trip_cause.ov, trip_cause.hs_oh,
        trip_cause.mot_oh, trip_cause.mot_ol, trip_cause.inv_ol};
    assign can_retry = eligible && retry_count_setting != RETRY_OFF
        && attempts < retry_count_setting;
    assign fire = rt == RT_WAIT && !manual_reset && rt_timer >= retry_interval_setting;
    assign count_chg = retry_count_setting != count_d;

    always_comb begin
        next_rt = rt;
        case (rt)
            RT_IDLE: begin
                if (trip_start) begin
                    next_rt = can_retry ? RT_WAIT : RT_ALARM;
                end
            end
            RT_WAIT: begin
                if (manual_reset || fire) begin
                    next_rt = RT_IDLE;
                end
            end
            RT_ALARM: begin
                if (manual_reset) begin
                    next_rt = RT_IDLE;
                end
            end
            default: next_rt = RT_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rt <= RT_IDLE;
            trip_d <= 1'b0;
            count_d <= 4'h0;
            rt_timer <= 8'h00;
            auto_reset_cmd <= 1'b0;
            retry_active_output <= 1'b0;
            alarm_out <= 1'b0;
        end else begin
            rt <= next_rt;
            trip_d <= trip_active;
            count_d <= retry_count_setting;
            rt_timer <= (next_rt != rt) ? 8'h00 : rt_timer + 8'(tick && rt_timer != 8'hFF);
            auto_reset_cmd <= fire;
            retry_active_output <= next_rt == RT_WAIT;
            alarm_out <= next_rt == RT_ALARM;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || manual_reset || count_chg) begin
            attempts <= 4'h0;
        end else if (fire) begin
            attempts <= attempts + 4'h1;
        end
    end

    // ************************************************
    // output terminals
    // ************************************************
    logic [2:0][7:0] out_assign;
    assign out_assign = {relay_output_assign, output_two_assign, output_one_assign};

    for (genvar gi = 0; gi < 3; gi++) begin : g_term
        always_ff @(posedge core_clk) begin
            if (reset) begin
                terminal_out[gi] <= 1'b0;
            end else begin
                terminal_out[gi] <= out_assign[gi] == RETRY_OUT_CODE && next_rt == RT_WAIT;
            end
        end
    end

    // ************************************************
    // cooling fan
    // ************************************************
    logic temp_s1, temp_s2, next_fan;
    logic [12:0] fan_hold;

    // off only when controlled, stopped, cool, hold spent
    assign next_fan = !(fan_control_select == FAN_CTRL && !drive_running
        && temp_s2 && fan_hold == 13'h0000);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            temp_s1 <= 1'b0;
            temp_s2 <= 1'b0;
            fan_on <= 1'b0;
            fan_hold <= 13'h0000;
        end else begin
            temp_s1 <= temp_low_pin;
            temp_s2 <= temp_s1;
            fan_on <= next_fan;
            if (next_fan && !fan_on) begin
                fan_hold <= 13'(FAN_HOLD_TENTHS);
            end else if (tick && fan_hold != 13'h0000) begin
                fan_hold <= fan_hold - 13'h0001;
            end
        end
    end

    // ************************************************
    // ramp
    // ************************************************
    drs_ramp_shape #(
        .FW(FW)
    ) u_ramp (
        .core_clk(core_clk),
        .reset(reset),
        .pattern(ramp_pattern_select),
        .target(target_freq),
        .max_freq(max_freq),
        .base_freq(base_freq),
        .step(ramp_step),
        .out_freq(out_freq)
    );

    // ************************************************
    // idle-speed search at start
    // ************************************************
    drs_search_st_t sr, next_sr;
    drs_search_t mode;
    logic [NUM_DIN-1:0] din_s1, din_s2, srch_in_hit;
    logic [7:0] sr_timer;
    logic srch_in, want_search, sr_end;

    for (genvar gi = 0; gi < NUM_DIN; gi++) begin : g_srch_in
        assign srch_in_hit[gi] = input_terminal_assign[gi] == SEARCH_IN_CODE && din_s2[gi];
    end
    assign srch_in = |srch_in_hit;
    assign mode = drs_search_t'(idle_search_select);
    assign want_search = (start_cmd && (mode == SEARCH_ALL || srch_in))
        || (restart_pf && (mode == SEARCH_PF || mode == SEARCH_ALL));
    assign sr_end = search_done || sr_timer >= 8'(SEARCH_MAX_TENTHS);

    always_comb begin
        next_sr = sr;
        case (sr)
            SR_IDLE: begin
                if (want_search) begin
                    next_sr = SR_DELAY;
                end
            end
            SR_DELAY: begin
                if (sr_timer >= search_delay_setting) begin
                    next_sr = SR_RUN;
                end
            end
            SR_RUN: begin
                if (sr_end) begin
                    next_sr = SR_IDLE;
                end
            end
            default: next_sr = SR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            din_s1 <= '0;
            din_s2 <= '0;
            sr <= SR_IDLE;
            sr_timer <= 8'h00;
            search_active <= 1'b0;
            accel_go <= 1'b0;
        end else begin
            din_s1 <= din_pin;
            din_s2 <= din_s1;
            sr <= next_sr;
            sr_timer <= (next_sr != sr) ? 8'h00 : sr_timer + 8'(tick && sr_timer != 8'hFF);
            search_active <= next_sr == SR_RUN;
            accel_go <= (sr == SR_RUN && sr_end)
                || (sr == SR_IDLE && (start_cmd || restart_pf) && !want_search);
        end
    end

    // ************************************************
    // motor parameter init
    // ************************************************
    drs_motor_par_t table_par;
    logic [1:0] init_sel_d;
    logic init_go, type_ok;

    drs_motor_table u_table (
        .capacity(rated_capacity_setting),
        .par(table_par),
        .band()
    );

    assign init_go = parameter_init_select == INIT_MOTOR && init_sel_d != INIT_MOTOR;
    assign type_ok = motor_type_select == MOTOR_STD || motor_type_select == MOTOR_OTHER;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            init_sel_d <= 2'h0;
            motor_par <= '0;
            init_done <= 1'b0;
        end else begin
            init_sel_d <= parameter_init_select;
            init_done <= init_go;
            if (init_go && type_ok) begin
                motor_par <= table_par;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_trip_new;
        rt == RT_IDLE && trip_start;
    endsequence

    property p_zero_off;
        s_trip_new and retry_count_setting == RETRY_OFF |=> alarm_out && !retry_active_output;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("retry with zero count");

    property p_ineligible;
        s_trip_new and !eligible |=> alarm_out;
    endproperty
    a_ineligible: assert property (p_ineligible) else $error("ineligible trip retried");

    property p_exhausted;
        s_trip_new and attempts >= retry_count_setting |=> alarm_out;
    endproperty
    a_exhausted: assert property (p_exhausted) else $error("retry beyond count");

    property p_retry_wait;
        s_trip_new and can_retry |=> retry_active_output && !alarm_out
            ##1 (!auto_reset_cmd || retry_interval_setting == 8'h00);
    endproperty
    a_retry_wait: assert property (p_retry_wait) else $error("retry not entered");

    property p_reset_interval;
        $rose(auto_reset_cmd) |-> $past(rt_timer) >= $past(retry_interval_setting)
            && $past(retry_active_output);
    endproperty
    a_reset_interval: assert property (p_reset_interval) else $error("early reset");

    property p_terminal;
        $past(output_one_assign) == RETRY_OUT_CODE |-> terminal_out[0] == retry_active_output;
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal mismatch");

    property p_fan_always;
        fan_control_select != FAN_CTRL |=> ##1 fan_on;
    endproperty
    a_fan_always: assert property (p_fan_always) else $error("fan off in mode 0");

    property p_fan_hold;
        $fell(fan_on) |-> $past(fan_hold) == 13'h0000 && $past(temp_s2) && !$past(drive_running);
    endproperty
    a_fan_hold: assert property (p_fan_hold) else $error("fan stopped early");

    property p_search_bound;
        sr == SR_RUN |-> sr_timer <= 8'(SEARCH_MAX_TENTHS);
    endproperty
    a_search_bound: assert property (p_search_bound) else $error("search too long");

    property p_search_start;
        sr == SR_IDLE && start_cmd && mode == SEARCH_ALL |=> sr == SR_DELAY;
    endproperty
    a_search_start: assert property (p_search_start) else $error("search not started");

endmodule // drs_top
